// ---- lpc_flash_consts.svh ----
// Constants for the flash pin front end
`ifndef LPC_FLASH_CONSTS_SVH
`define LPC_FLASH_CONSTS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define NIBBLE_W        4
`define STRAP_W         4
`define GPI_W           5
`define ROW_W           11
`define COL_W           9
`define FADDR_W         20
`define BYTE_W          8
`define BLOCK_W         4

// ****************************************************************
// Decode values
// ****************************************************************
`define LPC_START_NIB   4'h0
`define TOP_BLOCK_NUM   4'hF
`define STRAP_HI_LSB    2
`define SYNC_STAGES     2

`endif

// ---- lpc_flash_pkg.sv ----
// Types shared by the flash pin front end
package lpc_flash_pkg;

    // ****************************************************************
    // Hub link state
    // ****************************************************************
    typedef enum logic [1:0] {
        HUB_IDLE   = 2'b00,
        HUB_START  = 2'b01,
        HUB_ACTIVE = 2'b10
    } hub_state_t;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic       valid;
        logic       lpc_cycle;
        logic [3:0] nibble;
    } hub_rx_t;

    typedef struct packed {
        logic        valid;
        logic [19:0] addr;
        logic [7:0]  data;
    } factory_cmd_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] block;
        logic       lock_reg_set;
    } prot_req_t;

endpackage

// ---- pin_sync.sv ----
// Two-flop synchroniser for a group of pin levels
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level
);

    logic [W-1:0] meta_reg;

    generate
        if (W < 1) begin : g_chk
            $error("pin_sync width must be at least one");
        end
    endgenerate

    // First stage is read only by the second
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            level    <= '0;
        end else begin
            meta_reg <= pin;
            level    <= meta_reg;
        end
    end

endmodule

// ---- edge_finder.sv ----
// Rise and fall pulses of already synchronised levels
module edge_finder #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);

    logic [W-1:0] prev_reg;

    generate
        if (W < 1) begin : g_chk
            $error("edge_finder width must be at least one");
        end
    endgenerate

    // Starts high so a level high at release is no rise, but a level low at release gives one fall
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prev_reg <= '1;
        end else begin
            prev_reg <= level;
        end
    end

    assign rise = level & ~prev_reg;
    assign fall = ~level & prev_reg;

endmodule

// ---- lpc_flash_pin_frontend.sv ----
// Pin front end: interface select, frame control, straps, resets, guards
//
// Notes on behaviour
// - Interface_select low picks hub port, high picks factory port; taken in reset.
// - Frame_start_n low on a bus clock rise starts an operation.
// - Frame_start_n low during an operation aborts it.
// - Hub mode: four strap pins give the device identity.
// - LPC mode: two high strap pins are compared with address bits A21-A20.
// - LPC mode strap sense is inverted: low strap matches address bit one.
// - Five general inputs are offered to the host as a readable value.
// - Interface reset low holds reset, outputs off; release starts in read mode.
// - Internal reset is asserted when either reset pin is low.
// - Hub nibbles move in and out on bus clock edges.
// - Top_block_lock low blocks program and erase of block 15 only.
// - Main_block_guard_n low blocks program and erase of blocks 0 to 14.
// - Row bits latch on strobe fall, column bits on strobe rise.
// - Factory read drives the stored byte; factory write latches a command.
// - Factory data buffers are enabled only under output_en_n.
// - Factory writes to the command interface happen under store_strobe_n.
// - Supply lockout disables commands, aborts program and erase, then read mode.
// - Factory port treats every block as unprotected.
// - An abort by frame_start_n releases hub_io_nibble at once.
`include "lpc_flash_consts.svh"

module lpc_flash_pin_frontend #(
    parameter int GPI_W   = `GPI_W,
    parameter int STRAP_W = `STRAP_W
) (
    input  wire logic                         mclk,
    input  wire logic                         rst,
    // Hub / LPC side
    input  wire logic                         bus_clk,
    input  wire logic                         frame_start_n,
    input  wire logic [`NIBBLE_W-1:0]         hub_io_nibble_in,
    output logic      [`NIBBLE_W-1:0]         hub_io_nibble_out,
    output logic      [`NIBBLE_W-1:0]         hub_io_nibble_oe,
    input  wire logic [STRAP_W-1:0]           chip_select_strap,
    input  wire logic [GPI_W-1:0]             general_inputs,
    input  wire logic                         interface_select,
    input  wire logic                         interface_reset_n,
    input  wire logic                         cpu_reset_n,
    input  wire logic                         top_block_lock,
    input  wire logic                         main_block_guard_n,
    input  wire logic                         supply_lockout,
    // Factory side
    input  wire logic [`ROW_W-1:0]            mux_addr_pins,
    input  wire logic                         row_col_strobe,
    input  wire logic [`BYTE_W-1:0]           mux_data_pins_in,
    output logic      [`BYTE_W-1:0]           mux_data_pins_out,
    output logic      [`BYTE_W-1:0]           mux_data_pins_oe,
    input  wire logic                         output_en_n,
    input  wire logic                         store_strobe_n,
    // Core side
    output logic                              core_reset,
    output logic                              factory_mode,
    output logic                              cmd_enable,
    output logic                              pe_abort,
    output logic                              read_mode_entry,
    output logic                              op_start,
    output logic                              op_abort,
    output lpc_flash_pkg::hub_rx_t            hub_rx,
    input  wire logic                         op_done,
    input  wire logic [`NIBBLE_W-1:0]         tx_nibble,
    input  wire logic                         tx_drive,
    input  wire logic [`NIBBLE_W-1:0]         id_field,
    input  wire logic [1:0]                   addr_a21_a20,
    output logic                              id_match,
    output logic      [GPI_W-1:0]             gpi_value,
    input  wire lpc_flash_pkg::prot_req_t     prot_req,
    output logic                              prot_allowed,
    output logic                              prot_valid,
    output lpc_flash_pkg::factory_cmd_t       factory_cmd,
    output logic      [`FADDR_W-1:0]          factory_addr,
    input  wire logic [`BYTE_W-1:0]           read_byte
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    generate
        if (STRAP_W != `STRAP_W) begin : g_strap_chk
            $error("strap width must be four");
        end
        if (GPI_W < 1) begin : g_gpi_chk
            $error("general input width must be at least one");
        end
    endgenerate

    // ****************************************************************
    // Synchronisers for every pin
    // ****************************************************************
    localparam int CTRL_W = 10;

    logic [CTRL_W-1:0]      ctrl_s;
    logic [`NIBBLE_W-1:0]   nib_s;
    logic [STRAP_W-1:0]     strap_s;
    logic [GPI_W-1:0]       gpi_s;
    logic [`ROW_W-1:0]      addr_s;
    logic [`BYTE_W-1:0]     data_s;

    logic bclk_s;
    logic frame_n_s;
    logic if_sel_s;
    logic if_rst_n_s;
    logic cpu_rst_n_s;
    logic tbl_s;
    logic guard_n_s;
    logic lockout_s;
    logic rcs_s;
    logic store_n_s;
    logic oe_n_s;

    pin_sync #(.W(CTRL_W)) u_sync_ctrl (
        .mclk  (mclk),
        .rst   (rst),
        .pin   ({bus_clk, frame_start_n, interface_select,
                 interface_reset_n, cpu_reset_n, top_block_lock,
                 main_block_guard_n, supply_lockout, row_col_strobe,
                 store_strobe_n}),
        .level (ctrl_s)
    );

    pin_sync #(.W(`NIBBLE_W + STRAP_W + GPI_W + `ROW_W + `BYTE_W + 1))
    u_sync_data (
        .mclk  (mclk),
        .rst   (rst),
        .pin   ({hub_io_nibble_in, chip_select_strap, general_inputs,
                 mux_addr_pins, mux_data_pins_in, output_en_n}),
        .level ({nib_s, strap_s, gpi_s, addr_s, data_s, oe_n_s})
    );

    assign {bclk_s, frame_n_s, if_sel_s, if_rst_n_s, cpu_rst_n_s, tbl_s,
            guard_n_s, lockout_s, rcs_s, store_n_s} = ctrl_s;

    // ****************************************************************
    // Edges of bus clock and factory strobes
    // ****************************************************************
    logic [2:0] edge_rise;
    logic [2:0] edge_fall;
    logic       bclk_rise;
    logic       rcs_rise;
    logic       rcs_fall;
    logic       store_rise;

    edge_finder #(.W(3)) u_edges (
        .mclk  (mclk),
        .rst   (rst),
        .level ({bclk_s, rcs_s, store_n_s}),
        .rise  (edge_rise),
        .fall  (edge_fall)
    );

    assign bclk_rise  = edge_rise[2];
    assign rcs_rise   = edge_rise[1];
    assign rcs_fall   = edge_fall[1];
    assign store_rise = edge_rise[0];

    // ****************************************************************
    // Reset, interface choice, supply lockout
    // ****************************************************************
    logic int_reset;
    logic int_reset_reg;
    logic lockout_reg;

    assign int_reset = ~if_rst_n_s | ~cpu_rst_n_s;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            int_reset_reg <= 1'b1;
            lockout_reg   <= 1'b0;
        end else begin
            int_reset_reg <= int_reset;
            lockout_reg   <= lockout_s;
        end
    end

    assign core_reset = int_reset_reg;

    // Choice is only taken while held in reset, so a glitch later is harmless
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            factory_mode <= 1'b0;
        end else if (int_reset) begin
            factory_mode <= if_sel_s;
        end
    end

    assign cmd_enable = ~lockout_reg & ~int_reset_reg;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pe_abort        <= 1'b0;
            read_mode_entry <= 1'b0;
        end else begin
            pe_abort <= (lockout_s & ~lockout_reg)
                        | (int_reset & ~int_reset_reg);
            read_mode_entry <= (~lockout_s & lockout_reg & ~int_reset)
                               | (~int_reset & int_reset_reg & ~lockout_s);
        end
    end

    // ****************************************************************
    // Hub frame control
    // ****************************************************************
    lpc_flash_pkg::hub_state_t state_reg;
    logic                      lpc_reg;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= lpc_flash_pkg::HUB_IDLE;
            lpc_reg   <= 1'b0;
            op_start  <= 1'b0;
            op_abort  <= 1'b0;
        end else if (int_reset || factory_mode) begin
            state_reg <= lpc_flash_pkg::HUB_IDLE;
            op_start  <= 1'b0;
            op_abort  <= 1'b0;
        end else begin
            op_start <= 1'b0;
            op_abort <= 1'b0;
            if (bclk_rise) begin
                unique case (state_reg)
                    lpc_flash_pkg::HUB_IDLE: begin
                        if (!frame_n_s) begin
                            state_reg <= lpc_flash_pkg::HUB_START;
                            lpc_reg   <= (nib_s == `LPC_START_NIB);
                        end
                    end
                    lpc_flash_pkg::HUB_START: begin
                        // Last start nibble seen with frame low counts
                        if (!frame_n_s) begin
                            lpc_reg <= (nib_s == `LPC_START_NIB);
                        end else begin
                            state_reg <= lpc_flash_pkg::HUB_ACTIVE;
                            op_start  <= 1'b1;
                        end
                    end
                    lpc_flash_pkg::HUB_ACTIVE: begin
                        if (!frame_n_s) begin
                            state_reg <= lpc_flash_pkg::HUB_START;
                            lpc_reg   <= (nib_s == `LPC_START_NIB);
                            op_abort  <= 1'b1;
                        end else if (op_done) begin
                            state_reg <= lpc_flash_pkg::HUB_IDLE;
                        end
                    end
                    default: begin
                        state_reg <= lpc_flash_pkg::HUB_IDLE;
                    end
                endcase
            end
        end
    end

    // Received nibble per bus clock rise while a frame runs
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hub_rx <= '0;
        end else begin
            hub_rx.valid <= bclk_rise && frame_n_s && !int_reset
                            && !factory_mode
                            && state_reg != lpc_flash_pkg::HUB_IDLE;
            hub_rx.lpc_cycle <= lpc_reg;
            if (bclk_rise) begin
                hub_rx.nibble <= nib_s;
            end
        end
    end

    // ****************************************************************
    // Hub output drive
    // ****************************************************************
    logic hub_drive_reg;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hub_io_nibble_out <= '0;
            hub_drive_reg     <= 1'b0;
        end else if (int_reset || factory_mode || !frame_n_s) begin
            hub_drive_reg <= 1'b0;
        end else if (bclk_rise) begin
            hub_io_nibble_out <= tx_nibble;
            hub_drive_reg     <= tx_drive
                                 && state_reg == lpc_flash_pkg::HUB_ACTIVE;
        end
    end

    // Frame low cuts the drive in the same cycle, not a bus clock later
    assign hub_io_nibble_oe = {`NIBBLE_W{hub_drive_reg & frame_n_s
                                         & ~int_reset_reg}};

    // ****************************************************************
    // Identity straps and general inputs
    // ****************************************************************
    function automatic logic ident_match(
        input logic                 lpc,
        input logic [STRAP_W-1:0]   strap,
        input logic [`NIBBLE_W-1:0] field,
        input logic [1:0]           hi_addr
    );
        logic [1:0] strap_hi;
        strap_hi = strap[`STRAP_HI_LSB +: 2];
        if (lpc) begin
            ident_match = (hi_addr == ~strap_hi);
        end else begin
            ident_match = (field == strap);
        end
    endfunction

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            id_match  <= 1'b0;
            gpi_value <= '0;
        end else begin
            id_match  <= ident_match(lpc_reg, strap_s, id_field,
                                     addr_a21_a20);
            gpi_value <= gpi_s;
        end
    end

    // ****************************************************************
    // Block protection by pins
    // ****************************************************************
    logic top_block;

    assign top_block = (prot_req.block == `TOP_BLOCK_NUM);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prot_allowed <= 1'b0;
            prot_valid   <= 1'b0;
        end else begin
            prot_valid <= prot_req.valid && !int_reset;
            if (lockout_s || int_reset) begin
                prot_allowed <= 1'b0;
            end else if (factory_mode) begin
                prot_allowed <= 1'b1;
            end else if (top_block) begin
                prot_allowed <= tbl_s & ~prot_req.lock_reg_set;
            end else begin
                prot_allowed <= guard_n_s & ~prot_req.lock_reg_set;
            end
        end
    end

    // ****************************************************************
    // Factory port
    // ****************************************************************
    logic fact_live;

    assign fact_live = factory_mode & ~int_reset;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            factory_addr <= '0;
        end else if (fact_live) begin
            if (rcs_fall) begin
                factory_addr[`ROW_W-1:0] <= addr_s;
            end
            if (rcs_rise) begin
                factory_addr[`FADDR_W-1:`ROW_W] <= addr_s[`COL_W-1:0];
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            factory_cmd <= '0;
        end else begin
            factory_cmd.valid <= fact_live && store_rise
                                 && oe_n_s && !lockout_s;
            if (fact_live && store_rise) begin
                factory_cmd.addr <= factory_addr;
                factory_cmd.data <= data_s;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mux_data_pins_out <= '0;
        end else begin
            mux_data_pins_out <= read_byte;
        end
    end

    // Write strobe low wins so the bus never fights an incoming command
    assign mux_data_pins_oe = {`BYTE_W{fact_live & ~int_reset_reg & ~oe_n_s
                                       & store_n_s}};

endmodule

// ---- lpc_flash_pin_frontend_sva.sv ----
// Port-level assertions for the flash pin front end
module lpc_flash_pin_frontend_sva (
    input wire logic                     mclk,
    input wire logic                     rst,
    input wire logic                     interface_reset_n,
    input wire logic                     cpu_reset_n,
    input wire logic                     top_block_lock,
    input wire logic                     main_block_guard_n,
    input wire logic                     supply_lockout,
    input wire logic                     core_reset,
    input wire logic                     factory_mode,
    input wire logic                     cmd_enable,
    input wire logic                     op_start,
    input wire logic                     op_abort,
    input wire logic [3:0]               hub_io_nibble_oe,
    input wire logic [7:0]               mux_data_pins_oe,
    input wire lpc_flash_pkg::prot_req_t prot_req,
    input wire logic                     prot_valid,
    input wire logic                     prot_allowed
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_reset_pins: assert property (
        (!interface_reset_n || !cpu_reset_n) [*4] |-> core_reset)
        else $error("no internal reset for a low reset pin");
    a_reset_quiet: assert property (
        core_reset |-> hub_io_nibble_oe == 4'h0 && mux_data_pins_oe == 8'h00
            && !cmd_enable)
        else $error("outputs active while in reset");
    a_mode_hold: assert property (
        !core_reset |-> $stable(factory_mode))
        else $error("interface choice changed outside reset");
    a_hub_only: assert property (
        op_start || op_abort || hub_io_nibble_oe != 4'h0 |-> !factory_mode)
        else $error("hub activity in factory mode");
    a_factory_oe: assert property (
        mux_data_pins_oe != 8'h00 |-> factory_mode)
        else $error("factory data driven in hub mode");
    a_top_lock: assert property (
        prot_req.valid && prot_req.block == 4'hF && !top_block_lock
            && !factory_mode && !core_reset |=> prot_valid && !prot_allowed)
        else $error("top block not locked");
    a_main_guard: assert property (
        prot_req.valid && prot_req.block != 4'hF && !main_block_guard_n
            && !factory_mode && !core_reset |=> prot_valid && !prot_allowed)
        else $error("main block not guarded");
    a_factory_free: assert property (
        prot_req.valid && factory_mode && !core_reset && !supply_lockout
            |=> prot_valid && prot_allowed)
        else $error("block protected in factory mode");
endmodule

bind lpc_flash_pin_frontend lpc_flash_pin_frontend_sva chk (.*);

// ---- lpc_host_model.sv ----
// Host side of the hub link: bus clock, frame line and nibble lines
module lpc_host_model (
    output logic       bus_clk,
    output logic       frame_start_n,
    output logic [3:0] nib
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        bus_clk = 1'b0;
        frame_start_n = 1'b1;
        nib = 4'hF;
    end
    // One bus clock period; the clock rests low outside frames
    task automatic cyc(input logic fr, input logic [3:0] n);
        frame_start_n = fr;
        nib = n;
        #400 bus_clk = 1'b1;
        #400 bus_clk = 1'b0;
        // Released lines show the inverse so a stale value never passes
        nib = ~n;
    endtask
    task automatic idle();
        frame_start_n = 1'b1;
    endtask
endmodule

// ---- lpc_flash_pin_frontend_tb.sv ----
// Self-checking bench for the flash pin front end
module lpc_flash_pin_frontend_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, rst, bus_clk, frame_start_n, interface_select, clr, prot_valid;
    logic interface_reset_n, cpu_reset_n, top_block_lock, supply_lockout;
    logic main_block_guard_n, row_col_strobe, output_en_n, store_strobe_n;
    logic core_reset, factory_mode, cmd_enable, pe_abort, read_mode_entry;
    logic op_start, op_abort, op_done, tx_drive, id_match, prot_allowed;
    logic [3:0] hub_io_nibble_in, hub_io_nibble_out, hub_io_nibble_oe;
    logic [3:0] host_nib, chip_select_strap, tx_nibble, id_field;
    logic [4:0] general_inputs, gpi_value, seen;
    logic [10:0] mux_addr_pins;
    logic [7:0] mux_data_pins_in, mux_data_pins_out, mux_data_pins_oe;
    logic [7:0] read_byte, prog_data;
    logic [1:0] addr_a21_a20;
    logic [19:0] factory_addr;
    lpc_flash_pkg::hub_rx_t hub_rx;
    lpc_flash_pkg::prot_req_t prot_req;
    lpc_flash_pkg::factory_cmd_t factory_cmd, cmd_q;
    int n_errors, n_checks, cycles;
    // Block, top lock, main guard, lock reg, expected allowed
    localparam logic [7:0] PT [7] = '{8'hF4, 8'hF9, 8'hFE, 8'h35, 8'h38,
                                      8'hED, 8'h08};

    // Shared wires resolved from the front end's output enables
    assign hub_io_nibble_in = (hub_io_nibble_oe & hub_io_nibble_out)
                            | (~hub_io_nibble_oe & host_nib);
    assign mux_data_pins_in = (mux_data_pins_oe & mux_data_pins_out)
                            | (~mux_data_pins_oe & prog_data);

    lpc_flash_pin_frontend DUT (.*);
    lpc_host_model host (.bus_clk, .frame_start_n, .nib(host_nib));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // Sticky record of one-cycle pulses
    always @(posedge mclk) begin
        seen <= clr ? 5'h00 : seen | {op_start, op_abort, pe_abort,
                                      read_mode_entry, factory_cmd.valid};
        if (factory_cmd.valid) cmd_q <= factory_cmd;
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_errors++;
            conclude();
        end
    end

    task automatic w(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic chk(input string what, input logic [19:0] exp,
                       input logic [19:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic clear_seen();
        clr = 1'b1;
        w(1);
        clr = 1'b0;
    endtask
    task automatic frame(input logic [3:0] start);
        clear_seen();
        host.cyc(1'b0, start);
        host.cyc(1'b1, 4'h2);
        w(3);
    endtask
    task automatic pin_reset(input logic sel);
        interface_reset_n = 1'b0;
        interface_select = sel;
        w(4);
        interface_reset_n = 1'b1;
        w(5);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic t_reset();
        interface_reset_n = 1'b0;
        w(4);
        chk("core_reset", 1, core_reset);
        frame(4'hE);
        chk("op_start in reset", 0, seen[4]);
        interface_reset_n = 1'b1;
        w(5);
        chk("core_reset off", 0, core_reset);
        chk("read_mode_entry", 1, seen[1]);
        cpu_reset_n = 1'b0;
        w(4);
        chk("core_reset cpu", 1, core_reset);
        chk("pe_abort", 1, seen[2]);
        cpu_reset_n = 1'b1;
        w(5);
    endtask
    task automatic t_hub();
        chip_select_strap = 4'h5;
        id_field = 4'h5;
        frame(4'hE);
        chk("op_start", 1, seen[4]);
        chk("hub_rx", 6'h02, hub_rx);
        chk("hub id", 1, id_match);
        chk("gpi_value", 5'h15, gpi_value);
        id_field = 4'h4;
        w(2);
        chk("hub id miss", 0, id_match);
        chip_select_strap = 4'hB;
        addr_a21_a20 = 2'b01;
        frame(4'h0);
        chk("lpc id", 1, id_match);
        addr_a21_a20 = 2'b10;
        w(2);
        chk("lpc id miss", 0, id_match);
        tx_drive = 1'b1;
        host.cyc(1'b1, 4'h0);
        chk("nibble out", 4'hA, hub_io_nibble_out);
        chk("nibble oe", 4'hF, hub_io_nibble_oe);
        clear_seen();
        host.cyc(1'b0, 4'h0);
        chk("op_abort", 1, seen[3]);
        chk("oe on abort", 0, hub_io_nibble_oe);
        tx_drive = 1'b0;
        op_done = 1'b1;
        host.cyc(1'b1, 4'h3);
        host.cyc(1'b1, 4'h3);
        op_done = 1'b0;
        host.idle();
    endtask
    task automatic t_prot(input logic fac);
        foreach (PT[i]) begin
            top_block_lock = PT[i][3];
            main_block_guard_n = PT[i][2];
            w(4);
            prot_req = '{1'b1, PT[i][7:4], PT[i][1]};
            w(1);
            prot_req.valid = 1'b0;
            chk("prot_valid", 1, prot_valid);
            chk("prot_allowed", fac | PT[i][0], prot_allowed);
        end
    endtask
    task automatic t_factory();
        pin_reset(1'b1);
        chk("factory_mode", 1, factory_mode);
        frame(4'hE);
        chk("hub ignored", 0, seen[4]);
        mux_addr_pins = 11'h5A3;
        row_col_strobe = 1'b0;
        w(4);
        mux_addr_pins = 11'h0C5;
        row_col_strobe = 1'b1;
        w(4);
        chk("factory_addr", {9'h0C5, 11'h5A3}, factory_addr);
        store_strobe_n = 1'b0;
        w(3);
        store_strobe_n = 1'b1;
        w(4);
        chk("cmd valid", 1, seen[0]);
        chk("cmd data", 8'h40, cmd_q.data);
        chk("cmd addr", {9'h0C5, 11'h5A3}, cmd_q.addr);
        prog_data = 8'hBF;
        output_en_n = 1'b0;
        w(4);
        chk("data oe", 8'hFF, mux_data_pins_oe);
        chk("data out", 8'h3C, mux_data_pins_out);
        output_en_n = 1'b1;
        w(4);
        chk("data oe off", 0, mux_data_pins_oe);
        t_prot(1'b1);
        pin_reset(1'b0);
        chk("hub mode", 0, factory_mode);
    endtask
    task automatic t_lockout();
        clear_seen();
        supply_lockout = 1'b1;
        w(4);
        chk("cmd_enable off", 0, cmd_enable);
        chk("pe_abort", 1, seen[2]);
        supply_lockout = 1'b0;
        w(4);
        chk("cmd_enable on", 1, cmd_enable);
        chk("read mode", 1, seen[1]);
    endtask

    initial begin
        {rst, clr, interface_reset_n, cpu_reset_n} = 4'hB;
        {interface_select, supply_lockout, op_done, tx_drive} = 4'h0;
        {top_block_lock, main_block_guard_n, row_col_strobe} = 3'h7;
        {output_en_n, store_strobe_n} = 2'h3;
        chip_select_strap = 4'h0;
        general_inputs = 5'h15;
        {tx_nibble, id_field, addr_a21_a20} = 10'h280;
        {mux_addr_pins, prog_data, read_byte} = 27'h000403C;
        prot_req = '0;
        {n_errors, n_checks, cycles} = '0;
        w(4);
        rst = 1'b0;
        w(5);
        clr = 1'b0;
        t_reset();
        t_hub();
        t_prot(1'b0);
        t_factory();
        t_lockout();
        conclude();
    end
endmodule
